//--- tb/sbs_array_model.sv
// Behavioural memory array that answers the burst control block
`timescale 1ns/10ps

module sbs_array_model #(
    parameter int LANES  = sbs_pkg::DEF_LANES,
    parameter int ADDR_W = sbs_pkg::DEF_ADDR_W
) (
    input  wire logic                             clock,
    input  wire logic [ADDR_W-1:0]                addr,
    input  wire logic                             write_en,
    input  wire logic [LANES-1:0]                 lane_we,
    input  wire logic [LANES*sbs_pkg::LANE_W-1:0] wdata,
    output logic      [LANES*sbs_pkg::LANE_W-1:0] rdata
);
    localparam int LW = sbs_pkg::LANE_W;

    logic [LANES*LW-1:0] mem [logic [ADDR_W-1:0]];

    // Unwritten places give an address pattern, so any read can be predicted
    always_comb begin
        if (mem.exists(addr)) begin
            rdata = mem[addr];
        end else begin
            rdata = {LANES{addr[8:0] ^ 9'h15a}};
        end
    end

    // A lane takes its data bits and parity bit together
    always @(posedge clock) begin
        if (write_en) begin
            logic [LANES*LW-1:0] cur;
            cur = mem.exists(addr) ? mem[addr] : '0;
            for (int k = 0; k < LANES; k++) begin
                if (lane_we[k]) begin
                    cur[k*LW +: LW] = wdata[k*LW +: LW];
                end
            end
            mem[addr] = cur;
        end
    end
endmodule

//--- tb/sbs_burst_ctrl_tb.sv
// Self-checking bench for the synchronous burst SRAM control block
`timescale 1ns/10ps

`define CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("unexpected %s expected %h seen %h", what, exp, got); \
        end \
    end

module sbs_burst_ctrl_tb;
    localparam int LANES  = sbs_pkg::DEF_LANES;
    localparam int ADDR_W = sbs_pkg::DEF_ADDR_W;
    localparam int DW     = LANES * sbs_pkg::LANE_W;
    // Strobe codes: primary, processor, controller, advance, global write, qualifier
    localparam logic [5:0] DESEL = 6'b110111;
    localparam logic [5:0] START = 6'b001111;
    localparam logic [5:0] NXT   = 6'b011011;
    localparam logic [5:0] ALT   = 6'b101011;
    localparam logic [5:0] HOLD  = 6'b011111;

    logic              clk, srst, order_sel, pri_n, dep_hi, dep_lo_n, proc_n, ctrl_n;
    logic              adv_n, gw_n, bwe_n, oe_n, sleep, rd_en, wr_en, dq_oe_n, asleep;
    logic [LANES-1:0]  bws_n;
    logic [LANES-1:0]  lane_we;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] arr_addr;
    logic [DW-1:0]     dq_in;
    logic [DW-1:0]     rdata;
    logic [DW-1:0]     wdata;
    logic [DW-1:0]     dq_out;
    int                failures;
    int                total_checks;
    int                seed;

    sbs_burst_ctrl #(.LANES(LANES), .ADDR_W(ADDR_W)) sbs_burst_ctrl_i (
        .CLOCK(clk), .SRST(srst), .BURST_ORDER_SEL(order_sel), .CHIP_ENABLE_PRIMARY_N(pri_n),
        .DEPTH_ENABLE_HIGH(dep_hi), .DEPTH_ENABLE_LOW_N(dep_lo_n), .ADDRESS_STROBE_PROCESSOR_N(proc_n),
        .ADDRESS_STROBE_CONTROLLER_N(ctrl_n), .BURST_ADVANCE_N(adv_n), .GLOBAL_WRITE_N(gw_n),
        .BYTE_WRITE_QUALIFIER_N(bwe_n), .BYTE_LANE_SELECT_N(bws_n), .OUTPUT_ENABLE_N(oe_n),
        .SLEEP_REQUEST(sleep), .ADDRESS(addr), .DQ_IN(dq_in), .ARRAY_RDATA(rdata), .ARRAY_ADDR(arr_addr),
        .ARRAY_READ_EN(rd_en), .ARRAY_WRITE_EN(wr_en), .ARRAY_LANE_WE(lane_we), .ARRAY_WDATA(wdata),
        .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .SLEEP_ACTIVE(asleep));

    sbs_array_model #(.LANES(LANES), .ADDR_W(ADDR_W)) sbs_array_model_i (
        .clock(clk), .addr(arr_addr), .write_en(wr_en), .lane_we(lane_we), .wdata(wdata), .rdata(rdata));

    // Clock at 250 MHz
    always #2 clk = ~clk;

    function automatic logic [DW-1:0] pat(input logic [ADDR_W-1:0] x);
        return {LANES{x[8:0] ^ 9'h15a}};
    endfunction

    function automatic logic [1:0] bseq(input logic il, input logic [1:0] s, input logic [1:0] i);
        return il ? (s ^ i) : (s + i);
    endfunction

    // Inputs move on the falling edge, outputs are read there too
    task automatic cyc();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic ctl(input logic [5:0] v);
        {pri_n, proc_n, ctrl_n, adv_n, gw_n, bwe_n} = v;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read burst from a deselected state; address pins wander to prove they are ignored
    task automatic burst(input logic il, input logic [1:0] st);
        logic [ADDR_W-1:0] e;
        e = ADDR_W'($random(seed));
        e[ADDR_W-1] = 1'b0;
        e[1:0] = st;
        order_sel = il;
        ctl(DESEL);
        repeat (3) cyc();
        ctl(6'b001000);
        bws_n = '0;
        addr = e;
        cyc();
        `CHK("start read", 1'b1, rd_en);
        `CHK("start write", 1'b0, wr_en);
        `CHK("start address", e, arr_addr);
        `CHK("first cycle drive", 1'b1, dq_oe_n);
        bws_n = '1;
        for (int i = 1; i < 5; i++) begin
            ctl(i == 2 ? ALT : (i == 4 ? HOLD : NXT));
            addr = ADDR_W'($random(seed));
            cyc();
            `CHK("read data", pat(e), dq_out);
            `CHK("read drive", 1'b0, dq_oe_n);
            e[1:0] = (i < 4) ? bseq(il, st, 2'(i)) : e[1:0];
            `CHK("burst address", e, arr_addr);
            `CHK("burst read", 1'b1, rd_en);
        end
        oe_n = 1'b1;
        #0.5;
        `CHK("drive enable off", 1'b1, dq_oe_n);
        oe_n = 1'b0;
        #0.5;
        `CHK("drive enable on", 1'b0, dq_oe_n);
        ctl(DESEL);
        cyc();
        `CHK("deselect drive", 1'b1, dq_oe_n);
        $display("test burst order %0d start %0d done", il, st);
    endtask

    // Controller start, continue, suspend; output enable on for continue and suspend to see the mask
    task automatic wr_burst(input logic g);
        logic [ADDR_W-1:0] a;
        logic [LANES-1:0]  lanes;
        a = ADDR_W'($random(seed));
        a[ADDR_W-1] = 1'b1;
        bws_n = LANES'($random(seed));
        if (&bws_n) begin
            bws_n[0] = 1'b0;
        end
        lanes = g ? ~bws_n : '1;
        addr = a;
        for (int i = 0; i < 3; i++) begin
            oe_n = (i == 0);
            ctl(i == 0 ? {4'b0101, g, 1'b0} : {3'b011, i == 2, g, 1'b0});
            dq_in = DW'({$random(seed), $random(seed)});
            cyc();
            a[1:0] = (i == 1) ? bseq(order_sel, a[1:0], 2'd1) : a[1:0];
            `CHK("write enable", 1'b1, wr_en);
            `CHK("lane writes", lanes, lane_we);
            `CHK("write data", dq_in, wdata);
            `CHK("write address", a, arr_addr);
            `CHK("write drive mask", 1'b1, dq_oe_n);
        end
        ctl(DESEL);
        cyc();
        $display("test write burst global %0d done", !g);
    endtask

    // Write term corners: nothing qualified, qualifier with no lane, global alone
    task automatic wterm();
        for (int k = 0; k < 3; k++) begin
            ctl({4'b0101, k != 2, k != 1});
            bws_n = (k == 0) ? '0 : '1;
            cyc();
            `CHK("write term", k == 2, wr_en);
            `CHK("read term", k != 2, rd_en);
            if (k == 2) begin
                `CHK("global lanes", {LANES{1'b1}}, lane_we);
            end
            ctl(DESEL);
            cyc();
        end
        // Three deselect encodings, each right after a read start
        for (int v = 0; v < 3; v++) begin
            ctl(START);
            cyc();
            ctl(v == 0 ? DESEL : (v == 1 ? START : 6'b010111));
            dep_hi = (v != 1);
            dep_lo_n = (v == 2);
            cyc();
            `CHK("deselect read", 1'b0, rd_en);
            `CHK("deselect write", 1'b0, wr_en);
            `CHK("deselect drive", 1'b1, dq_oe_n);
            dep_hi = 1'b1;
            dep_lo_n = 1'b0;
        end
        $display("test write term and deselect done");
    endtask

    // Sleep entered while deselected, strobes idle after release
    task automatic sleep_test();
        int n;
        ctl(DESEL);
        cyc();
        sleep = 1'b1;
        repeat (2) cyc();
        `CHK("sleep entry", 1'b1, asleep);
        ctl(START);
        cyc();
        `CHK("asleep read", 1'b0, rd_en);
        `CHK("asleep drive", 1'b1, dq_oe_n);
        ctl(6'b111111);
        sleep = 1'b0;
        n = 0;
        while (asleep !== 1'b0 && n < 8) begin
            cyc();
            n++;
        end
        if (n == 8) begin
            `CHK("sleep exit", 1'b0, asleep);
            stop_test();
        end
        repeat (2) cyc();
        ctl(START);
        cyc();
        `CHK("read after wake", 1'b1, rd_en);
        ctl(DESEL);
        cyc();
        $display("test sleep done");
    endtask

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        seed = 32'hcb8275d9;
        failures = 0;
        total_checks = 0;
        {order_sel, dep_hi, dep_lo_n, oe_n, sleep} = 5'b01000;
        ctl(DESEL);
        bws_n = '1;
        addr = '0;
        dq_in = '0;
        repeat (4) @(negedge clk);
        `CHK("reset drive", 1'b1, dq_oe_n);
        `CHK("reset read", 1'b0, rd_en);
        srst = 1'b0;
        for (int il = 0; il < 2; il++) begin
            for (int st = 0; st < 4; st++) begin
                burst(1'(il), 2'(st));
                wr_burst(1'(st));
            end
        end
        repeat (4) burst(1'($random(seed)), 2'($random(seed)));
        wterm();
        sleep_test();
        stop_test();
    end
endmodule

//--- verilog/sbs_burst_ctrl.sv
// Control logic of a pipelined synchronous burst SRAM
`timescale 1ns/10ps

module sbs_burst_ctrl #(
    parameter int LANES  = sbs_pkg::DEF_LANES,
    parameter int ADDR_W = sbs_pkg::DEF_ADDR_W
) (
    input  wire logic                             CLOCK,
    input  wire logic                             SRST,
    input  wire logic                             BURST_ORDER_SEL,
    input  wire logic                             CHIP_ENABLE_PRIMARY_N,
    input  wire logic                             DEPTH_ENABLE_HIGH,
    input  wire logic                             DEPTH_ENABLE_LOW_N,
    input  wire logic                             ADDRESS_STROBE_PROCESSOR_N,
    input  wire logic                             ADDRESS_STROBE_CONTROLLER_N,
    input  wire logic                             BURST_ADVANCE_N,
    input  wire logic                             GLOBAL_WRITE_N,
    input  wire logic                             BYTE_WRITE_QUALIFIER_N,
    input  wire logic [LANES-1:0]                 BYTE_LANE_SELECT_N,
    input  wire logic                             OUTPUT_ENABLE_N,
    input  wire logic                             SLEEP_REQUEST,
    input  wire logic [ADDR_W-1:0]                ADDRESS,
    input  wire logic [LANES*sbs_pkg::LANE_W-1:0] DQ_IN,
    input  wire logic [LANES*sbs_pkg::LANE_W-1:0] ARRAY_RDATA,
    output logic      [ADDR_W-1:0]                ARRAY_ADDR,
    output logic                                  ARRAY_READ_EN,
    output logic                                  ARRAY_WRITE_EN,
    output logic      [LANES-1:0]                 ARRAY_LANE_WE,
    output logic      [LANES*sbs_pkg::LANE_W-1:0] ARRAY_WDATA,
    output logic      [LANES*sbs_pkg::LANE_W-1:0] DQ_OUT,
    output logic                                  DQ_OE_N,
    output logic                                  SLEEP_ACTIVE
);

    localparam int DATA_W    = LANES * sbs_pkg::LANE_W;
    localparam int UP_W      = ADDR_W - sbs_pkg::BURST_W;
    localparam int ENTRY_MAX = sbs_pkg::SLEEP_ENTRY_CYC;

    // Whole state of the block
    typedef struct packed {
        logic              sleep_s1;
        logic              sleep_s2;
        logic              order_s1;
        logic              order_s2;
        logic [UP_W-1:0]   upper;
        logic [1:0]        start;
        logic [1:0]        idx;
        logic [ADDR_W-1:0] addr;
        logic              rd_en;
        logic              wr_en;
        logic [LANES-1:0]  lane_we;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] dout;
        logic              drive;
    } sbs_state_t;

    sbs_state_t        st_r;
    sbs_state_t        st_nxt;
    sbs_pkg::sbs_op_t  op;
    sbs_pkg::sbs_strobe_t strobe;
    logic [LANES-1:0]  lanes;
    logic              asleep;

    // Combined write term from global write, qualifier and lane selects
    function automatic logic write_term(input logic gw_n, input logic bwe_n, input logic [LANES-1:0] bw_n);
        write_term = ~(~gw_n | (~bwe_n & ~(&bw_n)));
    endfunction

    // Lanes to write: global write takes all, otherwise qualified selects
    function automatic logic [LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                   input logic [LANES-1:0] bw_n);
        if (!gw_n) begin
            lane_mask = {LANES{1'b1}};
        end else if (!bwe_n) begin
            lane_mask = ~bw_n;
        end else begin
            lane_mask = {LANES{1'b0}};
        end
    endfunction

    // Burst address from start value and step index
    function automatic logic [1:0] burst_addr(input logic [1:0] start, input logic [1:0] idx,
                                              input logic interleave);
        if (interleave) begin
            burst_addr = start ^ idx;
        end else begin
            burst_addr = start + idx;
        end
    endfunction

    // Cycle decode, priority as in the cycle table
    function automatic sbs_pkg::sbs_op_t decode(input sbs_pkg::sbs_strobe_t s);
        logic all_en;
        all_en = ~s.primary_n & s.depth_high & ~s.depth_low_n;
        if ((s.primary_n & ~s.ctrl_n) |
            (~s.primary_n & ~(s.depth_high & ~s.depth_low_n) & (~s.proc_n | ~s.ctrl_n))) begin
            decode = sbs_pkg::SBS_OP_DESEL;
        end else if (all_en & ~s.proc_n) begin
            decode = sbs_pkg::SBS_OP_START_RD;
        end else if (all_en & ~s.ctrl_n) begin
            decode = s.write_n ? sbs_pkg::SBS_OP_START_RD : sbs_pkg::SBS_OP_START_WR;
        end else if (~s.advance_n) begin
            decode = s.write_n ? sbs_pkg::SBS_OP_NEXT_RD : sbs_pkg::SBS_OP_NEXT_WR;
        end else begin
            decode = s.write_n ? sbs_pkg::SBS_OP_HOLD_RD : sbs_pkg::SBS_OP_HOLD_WR;
        end
    endfunction

    // Strobes are synchronous to CLOCK and need no synchroniser
    always_comb begin
        strobe.primary_n   = CHIP_ENABLE_PRIMARY_N;
        strobe.depth_high  = DEPTH_ENABLE_HIGH;
        strobe.depth_low_n = DEPTH_ENABLE_LOW_N;
        strobe.proc_n      = ADDRESS_STROBE_PROCESSOR_N;
        strobe.ctrl_n      = ADDRESS_STROBE_CONTROLLER_N;
        strobe.advance_n   = BURST_ADVANCE_N;
        strobe.write_n     = write_term(GLOBAL_WRITE_N, BYTE_WRITE_QUALIFIER_N, BYTE_LANE_SELECT_N);
        lanes              = lane_mask(GLOBAL_WRITE_N, BYTE_WRITE_QUALIFIER_N, BYTE_LANE_SELECT_N);
        asleep             = st_r.sleep_s2;
        op                 = asleep ? sbs_pkg::SBS_OP_NONE : decode(strobe);
    end

    // Next state
    always_comb begin
        st_nxt = st_r;
        // Sleep and order select are asynchronous pins: two flops each
        st_nxt.sleep_s1 = SLEEP_REQUEST;
        st_nxt.sleep_s2 = st_r.sleep_s1;
        st_nxt.order_s1 = BURST_ORDER_SEL;
        st_nxt.order_s2 = st_r.order_s1;
        st_nxt.rd_en    = 1'b0;
        st_nxt.wr_en    = 1'b0;
        st_nxt.lane_we  = {LANES{1'b0}};
        case (op)
            sbs_pkg::SBS_OP_START_RD,
            sbs_pkg::SBS_OP_START_WR: begin
                // Burst counter reloads; upper bits frozen for the burst
                st_nxt.upper = ADDRESS[ADDR_W-1:sbs_pkg::BURST_W];
                st_nxt.start = ADDRESS[1:0];
                st_nxt.idx   = sbs_pkg::RST_BURST;
                st_nxt.addr  = ADDRESS;
            end
            sbs_pkg::SBS_OP_NEXT_RD,
            sbs_pkg::SBS_OP_NEXT_WR: begin
                st_nxt.idx  = st_r.idx + 2'h1;
                st_nxt.addr = {st_r.upper, burst_addr(st_r.start, st_r.idx + 2'h1, st_r.order_s2)};
            end
            default: begin
            end
        endcase
        case (op)
            sbs_pkg::SBS_OP_START_RD,
            sbs_pkg::SBS_OP_NEXT_RD,
            sbs_pkg::SBS_OP_HOLD_RD: begin
                st_nxt.rd_en = 1'b1;
            end
            sbs_pkg::SBS_OP_START_WR,
            sbs_pkg::SBS_OP_NEXT_WR,
            sbs_pkg::SBS_OP_HOLD_WR: begin
                // Write data and lane selects taken on this same edge
                st_nxt.wr_en   = 1'b1;
                st_nxt.lane_we = lanes;
                st_nxt.wdata   = DQ_IN;
            end
            default: begin
            end
        endcase
        // Output register loads one edge after the array read
        if (st_r.rd_en) begin
            st_nxt.dout = ARRAY_RDATA;
        end
        // Drive only for read data; a write or deselect drops it at once
        st_nxt.drive = st_r.rd_en & ~asleep & (op != sbs_pkg::SBS_OP_DESEL) &
                       ~st_nxt.wr_en;
    end

    // State register; reset clears every field to zero
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        ARRAY_ADDR     = st_r.addr;
        ARRAY_READ_EN  = st_r.rd_en;
        ARRAY_WRITE_EN = st_r.wr_en;
        ARRAY_LANE_WE  = st_r.lane_we;
        ARRAY_WDATA    = st_r.wdata;
        DQ_OUT         = st_r.dout;
        SLEEP_ACTIVE   = st_r.sleep_s2;
    end

    // Output enable gates the pads without a clock, so this one is not a flop
    assign DQ_OE_N = ~(st_r.drive & ~OUTPUT_ENABLE_N & ~st_r.sleep_s2);

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    AST_LINEAR_STEP: assert property (
        ((op == sbs_pkg::SBS_OP_NEXT_RD || op == sbs_pkg::SBS_OP_NEXT_WR) && !st_r.order_s2)
        |=> ARRAY_ADDR[1:0] == 2'($past(st_r.start) + $past(st_r.idx) + 2'h1))
        else $error("linear burst step wrong");

    AST_INTERLEAVE_STEP: assert property (
        ((op == sbs_pkg::SBS_OP_NEXT_RD || op == sbs_pkg::SBS_OP_NEXT_WR) && st_r.order_s2)
        |=> ARRAY_ADDR[1:0] == ($past(st_r.start) ^ 2'($past(st_r.idx) + 2'h1)))
        else $error("interleaved burst step wrong");

    AST_SLEEP_ENTRY: assert property (
        $rose(SLEEP_REQUEST) |-> ##[1:ENTRY_MAX] SLEEP_ACTIVE)
        else $error("sleep not entered in two cycles");

    AST_SLEEP_QUIET: assert property (
        SLEEP_ACTIVE |=> DQ_OE_N && !ARRAY_WRITE_EN && !ARRAY_READ_EN)
        else $error("activity while asleep");

    AST_DESELECT: assert property (
        op == sbs_pkg::SBS_OP_DESEL |=> DQ_OE_N && !ARRAY_READ_EN && !ARRAY_WRITE_EN)
        else $error("deselect did not tri-state");

    AST_START_READ: assert property (
        (op == sbs_pkg::SBS_OP_START_RD && !ADDRESS_STROBE_PROCESSOR_N)
        |=> ARRAY_READ_EN && !ARRAY_WRITE_EN && ARRAY_ADDR == $past(ADDRESS))
        else $error("processor start not a read at external address");

    AST_START_WRITE: assert property (
        op == sbs_pkg::SBS_OP_START_WR
        |=> ARRAY_WRITE_EN && ARRAY_ADDR == $past(ADDRESS) && ARRAY_WDATA == $past(DQ_IN))
        else $error("controller write start wrong");

    AST_HOLD_ADDR: assert property (
        (op == sbs_pkg::SBS_OP_HOLD_RD || op == sbs_pkg::SBS_OP_HOLD_WR)
        |=> ARRAY_ADDR == $past(ARRAY_ADDR) && (ARRAY_READ_EN != ARRAY_WRITE_EN))
        else $error("suspend moved the address");

    AST_LANES: assert property (
        (op == sbs_pkg::SBS_OP_NEXT_WR && GLOBAL_WRITE_N)
        |=> ARRAY_LANE_WE == ~$past(BYTE_LANE_SELECT_N))
        else $error("lane write enables wrong");

    AST_WRITE_MASK: assert property (
        ARRAY_WRITE_EN |-> DQ_OE_N)
        else $error("data driven during write");

    AST_READ_PIPE: assert property (
        (ARRAY_READ_EN && !SLEEP_ACTIVE && !OUTPUT_ENABLE_N
         && (op == sbs_pkg::SBS_OP_NEXT_RD || op == sbs_pkg::SBS_OP_HOLD_RD))
        |=> (!DQ_OE_N || OUTPUT_ENABLE_N || SLEEP_ACTIVE) && DQ_OUT == $past(ARRAY_RDATA))
        else $error("read data not presented on next edge");

    // Cycle types taken from the decode function, results checked at the array outputs
    AST_NEXT_READ: assert property (
        op == sbs_pkg::SBS_OP_NEXT_RD
        |=> ARRAY_READ_EN && !ARRAY_WRITE_EN)
        else $error("continue read did not read");

    AST_NEXT_WRITE: assert property (
        op == sbs_pkg::SBS_OP_NEXT_WR
        |=> ARRAY_WRITE_EN && !ARRAY_READ_EN && ARRAY_WDATA == $past(DQ_IN))
        else $error("continue write did not write");

    AST_HOLD_WRITE: assert property (
        op == sbs_pkg::SBS_OP_HOLD_WR
        |=> ARRAY_WRITE_EN && ARRAY_ADDR == $past(ARRAY_ADDR))
        else $error("suspended write moved or dropped");

    AST_WRITE_TERM: assert property (
        strobe.write_n == (GLOBAL_WRITE_N && (BYTE_WRITE_QUALIFIER_N || &BYTE_LANE_SELECT_N)))
        else $error("combined write term wrong");

    // Processor start stays a read even with every write input low
    AST_PROC_READ: assert property (
        (!CHIP_ENABLE_PRIMARY_N && DEPTH_ENABLE_HIGH && !DEPTH_ENABLE_LOW_N
         && !ADDRESS_STROBE_PROCESSOR_N && !SLEEP_ACTIVE)
        |=> ARRAY_READ_EN && !ARRAY_WRITE_EN)
        else $error("processor start wrote");

    AST_DESEL_DEPTH: assert property (
        (!CHIP_ENABLE_PRIMARY_N && !(DEPTH_ENABLE_HIGH && !DEPTH_ENABLE_LOW_N)
         && !ADDRESS_STROBE_PROCESSOR_N && !SLEEP_ACTIVE)
        |=> !ARRAY_READ_EN && !ARRAY_WRITE_EN)
        else $error("depth deselect still accessed");

    AST_START_LANES: assert property (
        (op == sbs_pkg::SBS_OP_START_WR && GLOBAL_WRITE_N)
        |=> ARRAY_LANE_WE == ~$past(BYTE_LANE_SELECT_N))
        else $error("start write lanes wrong");

    AST_WRITE_SOME_LANE: assert property (
        op == sbs_pkg::SBS_OP_START_WR |=> ARRAY_LANE_WE != '0)
        else $error("write with no lane enabled");

    AST_READ_NO_LANE: assert property (
        op == sbs_pkg::SBS_OP_START_RD |=> ARRAY_LANE_WE == '0)
        else $error("lane enabled on a read");

    // Output enable has no clock in its path, so it must act in the same cycle
    AST_OE_COMB: assert property (
        OUTPUT_ENABLE_N |-> DQ_OE_N)
        else $error("pads driven with output enable off");

    AST_DRIVE_READ: assert property (
        !DQ_OE_N |-> !OUTPUT_ENABLE_N && !ARRAY_WRITE_EN)
        else $error("pads driven outside a read");

    AST_FIRST_TRISTATE: assert property (
        (op == sbs_pkg::SBS_OP_START_RD && !ARRAY_READ_EN)
        |=> DQ_OE_N)
        else $error("first cycle after select was driven");

    AST_UPPER_FIXED: assert property (
        (op == sbs_pkg::SBS_OP_NEXT_RD || op == sbs_pkg::SBS_OP_NEXT_WR)
        |=> ARRAY_ADDR[ADDR_W-1:2] == $past(ARRAY_ADDR[ADDR_W-1:2]))
        else $error("upper address moved in burst");

    AST_COUNTER_LOAD: assert property (
        (op == sbs_pkg::SBS_OP_START_RD || op == sbs_pkg::SBS_OP_START_WR)
        |=> st_r.idx == 2'h0 && st_r.start == $past(ADDRESS[1:0]))
        else $error("burst counter not reloaded");

    // Sleep keeps pads off and the address still
    AST_SLEEP_PADS: assert property (
        SLEEP_ACTIVE |-> DQ_OE_N)
        else $error("pads driven while asleep");

    AST_SLEEP_ADDR: assert property (
        SLEEP_ACTIVE |=> $stable(ARRAY_ADDR))
        else $error("address moved while asleep");

    AST_SLEEP_EXIT: assert property (
        $fell(SLEEP_REQUEST) |-> ##[1:ENTRY_MAX] !SLEEP_ACTIVE)
        else $error("sleep not left in two cycles");

    AST_CTRL_READ: assert property (
        (op == sbs_pkg::SBS_OP_START_RD && ADDRESS_STROBE_PROCESSOR_N)
        |=> ARRAY_READ_EN && ARRAY_ADDR == $past(ADDRESS))
        else $error("controller read start wrong");

endmodule

//--- verilog/sbs_pkg.sv
// Shared constants and types for the synchronous burst SRAM control block
// Functional notes
// - Order select low: counter steps linearly from start, wrapping modulo four.
// - Order select high or open: next address is start XOR step index.
// - Sleep request takes effect within two clock periods.
// - While asleep all other inputs are ignored and data stays tri-stated.
// - Deselect edges: primary disabled with controller strobe, or depth disabled with any strobe.
// - All enables plus processor strobe loads address and starts a read burst.
// - All enables, controller strobe only, write term low: load address, start write burst.
// - No new strobe and advance low: read at the next burst address.
// - Same strobe condition with write term low: advance and write.
// - No new strobe and advance high: repeat read at current burst address.
// - No new strobe, advance high, write term low: write again without advancing.
// - Write term low on global write, or qualifier with any lane select low.
// - A processor strobe start is always a read, whatever the write inputs.
// - Data drive follows cycle type and output enable, enable acting combinationally.
// - Output enable masked in writes; reads drive only when enabled and selected.
// - Narrow organisations: read when no lane qualified, write selected lanes with parity.
// - Wide organisation has eight lane selects, each writing its lane and parity.
// - Lane selects are sampled on the edge; any lane combination may write.
// - Read data leaves the output register one edge after address capture.
package sbs_pkg;

    // Geometry
    localparam int LANE_W        = 9;       // Eight data bits plus parity
    localparam int DEF_LANES     = 4;       // x36 organisation
    localparam int DEF_ADDR_W    = 21;
    localparam int BURST_W       = 2;

    // Timing, in ns and in cycles
    localparam int CLK_PERIOD_NS      = 4;
    localparam int SLEEP_ENTRY_TIME_NS    = 2 * CLK_PERIOD_NS;
    localparam int SLEEP_RECOVERY_TIME_NS = 2 * CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_CYC    = (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                        : SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
    localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values
    localparam logic [1:0] RST_BURST = 2'h0;
    localparam logic       RST_FLAG  = 1'b0;

    // Cycle type decoded at a clock edge
    typedef enum logic [2:0] {
        SBS_OP_NONE     = 3'b000,
        SBS_OP_DESEL    = 3'b001,
        SBS_OP_START_RD = 3'b010,
        SBS_OP_START_WR = 3'b011,
        SBS_OP_NEXT_RD  = 3'b100,
        SBS_OP_NEXT_WR  = 3'b101,
        SBS_OP_HOLD_RD  = 3'b110,
        SBS_OP_HOLD_WR  = 3'b111
    } sbs_op_t;

    // Strobe group sampled at each edge
    typedef struct packed {
        logic primary_n;
        logic depth_high;
        logic depth_low_n;
        logic proc_n;
        logic ctrl_n;
        logic advance_n;
        logic write_n;     // Combined write term
    } sbs_strobe_t;

endpackage
